// ===== hdl/rcwd_pkg.sv
package rcwd_pkg;
    // Configuration word field positions
    localparam int CSFIVE_BIT    = 21;
    localparam int XFER_CODE_LO  = 22;
    localparam int XFER_CODE_HI  = 23;
    localparam int LE_BIT        = 24;
    localparam int MUNGED_BIT    = 25;
    localparam int RSV26_BIT     = 26;
    localparam int RSV27_BIT     = 27;
    localparam int MODE_HI_LO    = 28;
    localparam int MODE_HI_HI    = 30;
    localparam int RSV31_BIT     = 31;

    // Transfer-code pin patterns
    localparam logic [1:0] XFER_CODE_PINS = 2'h0;
    localparam logic [1:0] XFER_CODE_BANK = 2'h2;

    // Reset values
    localparam logic [31:0] DEFAULT_WORD = 32'h00000000;
    localparam logic [4:0]  MODE_RESET   = 5'h00;

    // Window for the word to arrive, in input clock cycles
    localparam int          WORD_WINDOW_CYC = 1024;
    localparam logic [10:0] WINDOW_LAST     = 11'(WORD_WINDOW_CYC - 1);

    // Number of internal peripherals with a clock mask, and of cores
    localparam int NUM_PERIPH = 8;
    localparam int NUM_CORES  = 4;

    typedef enum logic [1:0] {
        RCWD_WAITWORD,
        RCWD_DONE
    } rcwd_state_e;
endpackage

// ===== hdl/rcwd_core_power.sv
`timescale 1ns/10ps
module rcwd_core_power (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Control
    input  wire logic anyDeviceReset,
    input  wire logic stopReq,
    input  wire logic waitReq,
    input  wire logic irqReq,
    input  wire logic debugReq,
    // Status
    output logic      coreStopped,
    output logic      coreWaiting
);
    logic stopped_ff;
    logic waiting_ff;

    // Stop mode left only through a device reset
    always_ff @(posedge clock) begin
        if (reset || anyDeviceReset) begin
            stopped_ff <= 1'b0;
        end else if (stopReq) begin
            stopped_ff <= 1'b1;
        end
    end

    // Wait mode left on interrupt, reset or debug
    always_ff @(posedge clock) begin
        if (reset || anyDeviceReset) begin
            waiting_ff <= 1'b0;
        end else if (irqReq || debugReq) begin
            waiting_ff <= 1'b0;
        end else if (waitReq && !stopped_ff) begin
            waiting_ff <= 1'b1;
        end
    end

    assign coreStopped = stopped_ff;
    assign coreWaiting = waiting_ff;
endmodule

// ===== hdl/rcwd_clock_gate.sv
`timescale 1ns/10ps
module rcwd_clock_gate (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Control
    input  wire logic maskEn,
    input  wire logic clockIn,
    // Gated output
    output logic      clockOut
);
    logic mask_ff;

    // Mask sampled each cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            mask_ff <= 1'b0;
        end else begin
            mask_ff <= maskEn;
        end
    end

    assign clockOut = clockIn & ~mask_ff;
endmodule

// ===== hdl/reset_config_word_decode.sv
`timescale 1ns/10ps
module reset_config_word_decode (
    // Clock and reset
    input  wire logic                            clock,
    input  wire logic                            reset,
    // Device resets
    input  wire logic                            power_on_reset_n,
    input  wire logic                            hard_reset_n,
    input  wire logic                            soft_reset_n,
    // Configuration word input
    input  wire logic                            cfgWordValid,
    input  wire logic [31:0]                     cfgWordData,
    // Clock mode pins
    input  wire logic [1:0]                      clockModePins,
    // Interface configuration writes
    input  wire logic                            sysCfgWrite,
    input  wire logic                            bus_clock_output_disable,
    input  wire logic [rcwd_pkg::NUM_PERIPH-1:0] periphClockMask,
    // Core power requests
    input  wire logic [rcwd_pkg::NUM_CORES-1:0]  coreStopReq,
    input  wire logic [rcwd_pkg::NUM_CORES-1:0]  coreWaitReq,
    input  wire logic [rcwd_pkg::NUM_CORES-1:0]  coreIrqReq,
    input  wire logic [rcwd_pkg::NUM_CORES-1:0]  coreDebugReq,
    // Clocks to gate
    input  wire logic                            busClockIn,
    input  wire logic [rcwd_pkg::NUM_PERIPH-1:0] periphClockIn,
    // Decoded configuration
    output logic [31:0]                          hard_reset_config_word,
    output logic                                 cfgDone,
    output logic                                 chip_select_five_pin_cfg,
    output logic                                 chipSelectFiveEn,
    output logic                                 busControlOneEn,
    output logic [1:0]                           transfer_code_pin_cfg,
    output logic                                 transferCodeEn,
    output logic                                 bankSelectEn,
    output logic                                 host_little_endian_sel,
    output logic                                 munged_endian_sel,
    output logic                                 reservedBitsBad,
    output logic [4:0]                           clock_mode_bits,
    output logic [4:0]                           systemPllMult,
    // Clock outputs
    output logic                                 bus_clock_output,
    output logic [rcwd_pkg::NUM_PERIPH-1:0]      periphClockOut,
    // Core power status
    output logic [rcwd_pkg::NUM_CORES-1:0]       coreStopped,
    output logic [rcwd_pkg::NUM_CORES-1:0]       coreWaiting
);
    rcwd_pkg::rcwd_state_e state_ff;
    rcwd_pkg::rcwd_state_e nxt_state;
    logic [10:0]                     winCnt_ff;
    logic [31:0]                     word_ff;
    logic [1:0]                      modePins_ff;
    logic [4:0]                      pllMult_ff;
    logic                            pllLoaded_ff;
    logic                            porPrev_ff;
    logic                            clkDis_ff;
    logic [rcwd_pkg::NUM_PERIPH-1:0] perMask_ff;
    logic                            hardAsserted;
    logic                            porRise;
    logic                            anyDevReset;
    logic                            timedOut;

    // Field extraction shared by decode paths
    function automatic logic [1:0] xfer_code_field(input logic [31:0] w);
        xfer_code_field = w[rcwd_pkg::XFER_CODE_HI:rcwd_pkg::XFER_CODE_LO];
    endfunction

    function automatic logic [2:0] mode_high(input logic [31:0] w);
        mode_high = w[rcwd_pkg::MODE_HI_HI:rcwd_pkg::MODE_HI_LO];
    endfunction

    assign hardAsserted = !hard_reset_n || !power_on_reset_n;
    assign porRise      = power_on_reset_n && !porPrev_ff;
    assign anyDevReset  = hardAsserted || !soft_reset_n;
    assign timedOut     = (winCnt_ff == rcwd_pkg::WINDOW_LAST);

    // Power-on reset history, idle high so no false edge
    always_ff @(posedge clock) begin
        if (reset) begin
            porPrev_ff <= 1'b1;
        end else begin
            porPrev_ff <= power_on_reset_n;
        end
    end

    // Loader sequencing
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            rcwd_pkg::RCWD_WAITWORD: begin
                if (cfgWordValid || timedOut) begin
                    nxt_state = rcwd_pkg::RCWD_DONE;
                end
            end
            rcwd_pkg::RCWD_DONE: begin
                nxt_state = rcwd_pkg::RCWD_DONE;
            end
            default: begin
                nxt_state = rcwd_pkg::RCWD_WAITWORD;
            end
        endcase
        if (hardAsserted) begin
            nxt_state = rcwd_pkg::RCWD_WAITWORD;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff <= rcwd_pkg::RCWD_WAITWORD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Arrival window counter
    always_ff @(posedge clock) begin
        if (reset || hardAsserted) begin
            winCnt_ff <= 11'h000;
        end else if (state_ff == rcwd_pkg::RCWD_WAITWORD && !timedOut) begin
            winCnt_ff <= winCnt_ff + 11'h001;
        end
    end

    // Configuration word capture
    always_ff @(posedge clock) begin
        if (reset) begin
            word_ff <= rcwd_pkg::DEFAULT_WORD;
        end else if (state_ff == rcwd_pkg::RCWD_WAITWORD && !hardAsserted) begin
            if (cfgWordValid) begin
                word_ff <= cfgWordData;
            end else if (timedOut) begin
                word_ff <= rcwd_pkg::DEFAULT_WORD;
            end
        end
    end

    // Low clock mode pins at power-on release
    always_ff @(posedge clock) begin
        if (reset) begin
            modePins_ff <= 2'h0;
        end else if (porRise && !hard_reset_n) begin
            modePins_ff <= clockModePins;
        end
    end

    // PLL multiplier loads once per power-on
    always_ff @(posedge clock) begin
        if (reset || !power_on_reset_n) begin
            pllLoaded_ff <= 1'b0;
            pllMult_ff   <= rcwd_pkg::MODE_RESET;
        end else if (!pllLoaded_ff && state_ff == rcwd_pkg::RCWD_DONE) begin
            pllLoaded_ff <= 1'b1;
            pllMult_ff   <= {mode_high(word_ff), modePins_ff};
        end
    end

    // Interface configuration bits
    always_ff @(posedge clock) begin
        if (reset || hardAsserted) begin
            clkDis_ff  <= 1'b0;
            perMask_ff <= '0;
        end else if (sysCfgWrite) begin
            clkDis_ff  <= bus_clock_output_disable;
            perMask_ff <= periphClockMask;
        end
    end

    // Decode of held word
    assign hard_reset_config_word   = word_ff;
    assign cfgDone                  = (state_ff == rcwd_pkg::RCWD_DONE);
    assign chip_select_five_pin_cfg =
        word_ff[rcwd_pkg::CSFIVE_BIT];
    assign chipSelectFiveEn =
        !word_ff[rcwd_pkg::CSFIVE_BIT];
    assign busControlOneEn =
        word_ff[rcwd_pkg::CSFIVE_BIT];
    assign transfer_code_pin_cfg    = xfer_code_field(word_ff);
    assign transferCodeEn =
        (xfer_code_field(word_ff) == rcwd_pkg::XFER_CODE_PINS);
    assign bankSelectEn =
        (xfer_code_field(word_ff) == rcwd_pkg::XFER_CODE_BANK);
    assign host_little_endian_sel   = word_ff[rcwd_pkg::LE_BIT];
    assign munged_endian_sel        = word_ff[rcwd_pkg::LE_BIT]
                                    & word_ff[rcwd_pkg::MUNGED_BIT];
    assign reservedBitsBad = word_ff[rcwd_pkg::RSV26_BIT]
                           | word_ff[rcwd_pkg::RSV31_BIT]
                           | (cfgWordValid_seen() & ~word_ff[rcwd_pkg::RSV27_BIT]);
    assign clock_mode_bits = {mode_high(word_ff), modePins_ff};
    assign systemPllMult   = pllMult_ff;

    // Flag applies only to supplied words, not the default
    function automatic logic cfgWordValid_seen();
        cfgWordValid_seen = (word_ff != rcwd_pkg::DEFAULT_WORD);
    endfunction

    // Bus clock output gate
    rcwd_clock_gate uBusGate (
        .clock    (clock),
        .reset    (reset),
        .maskEn   (clkDis_ff),
        .clockIn  (busClockIn),
        .clockOut (bus_clock_output)
    );

    // Peripheral clock gates and core power control
    genvar gi;
    generate
        for (gi = 0; gi < rcwd_pkg::NUM_PERIPH; gi++) begin : gPer
            rcwd_clock_gate uPerGate (
                .clock    (clock),
                .reset    (reset),
                .maskEn   (perMask_ff[gi]),
                .clockIn  (periphClockIn[gi]),
                .clockOut (periphClockOut[gi])
            );
        end
        for (gi = 0; gi < rcwd_pkg::NUM_CORES; gi++) begin : gCore
            rcwd_core_power uCore (
                .clock          (clock),
                .reset          (reset),
                .anyDeviceReset (anyDevReset),
                .stopReq        (coreStopReq[gi]),
                .waitReq        (coreWaitReq[gi]),
                .irqReq         (coreIrqReq[gi]),
                .debugReq       (coreDebugReq[gi]),
                .coreStopped    (coreStopped[gi]),
                .coreWaiting    (coreWaiting[gi])
            );
        end
    endgenerate
endmodule

// ===== testbench/rcwd_word_source.sv
`timescale 1ns/10ps
module rcwd_word_source (
    // Clock
    input  wire logic        clock,
    // Bench command
    input  wire logic        sendGo,
    input  wire logic [31:0] sendWord,
    // Word bus
    output logic             cfgWordValid,
    output logic [31:0]      cfgWordData
);
    initial begin
        cfgWordValid = 1'b0;
        cfgWordData  = 32'h0;
    end
    // One-cycle word, reserved bits forced, bus scrambled when idle
    always @(posedge clock) begin
        cfgWordValid <= sendGo;
        if (sendGo) begin
            cfgWordData <= {1'b0, sendWord[30:28], 2'h2, sendWord[25:0]};
        end else begin
            cfgWordData <= ~cfgWordData;
        end
    end
endmodule

// ===== testbench/rcwd_monitor.sv
`timescale 1ns/10ps
module rcwd_monitor (
    // Clock and resets
    input wire logic                           clock,
    input wire logic                           reset,
    input wire logic                           power_on_reset_n,
    input wire logic                           hard_reset_n,
    input wire logic                           soft_reset_n,
    // Inputs
    input wire logic                           sysCfgWrite,
    input wire logic                           bus_clock_output_disable,
    input wire logic                           busClockIn,
    input wire logic [rcwd_pkg::NUM_CORES-1:0] coreIrqReq,
    input wire logic [rcwd_pkg::NUM_CORES-1:0] coreDebugReq,
    // Outputs
    input wire logic [31:0]                    hard_reset_config_word,
    input wire logic                           cfgDone,
    input wire logic                           chipSelectFiveEn,
    input wire logic                           busControlOneEn,
    input wire logic                           transferCodeEn,
    input wire logic                           bankSelectEn,
    input wire logic                           host_little_endian_sel,
    input wire logic                           munged_endian_sel,
    input wire logic [4:0]                     clock_mode_bits,
    input wire logic [4:0]                     systemPllMult,
    input wire logic                           bus_clock_output,
    input wire logic [rcwd_pkg::NUM_CORES-1:0] coreStopped,
    input wire logic [rcwd_pkg::NUM_CORES-1:0] coreWaiting
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire [31:0] w = hard_reset_config_word;
    wire        anyRstN = power_on_reset_n && hard_reset_n;

    cs_five_pin_a: assert property (
        chipSelectFiveEn == !w[21] && busControlOneEn == w[21])
        else $error("chip select five decode off");
    tcode_pins_a: assert property (
        transferCodeEn == (w[23:22] == 2'h0) && bankSelectEn == (w[23:22] == 2'h2))
        else $error("transfer code decode off");
    host_endian_a: assert property (
        host_little_endian_sel == w[24] && munged_endian_sel == (w[24] && w[25]))
        else $error("endian decode off");
    mode_high_a: assert property (
        clock_mode_bits[4:2] == w[30:28])
        else $error("clock mode high bits off");
    word_hold_a: assert property (
        cfgDone && $past(cfgDone) |-> $stable(w))
        else $error("word changed while done");
    pll_keep_a: assert property (
        $past(cfgDone, 2) && power_on_reset_n && $past(power_on_reset_n)
        |-> $stable(systemPllMult)) else $error("pll multiplier changed");
    stop_stays_a: assert property (
        anyRstN && soft_reset_n |=> (coreStopped & $past(coreStopped)) == $past(coreStopped))
        else $error("stop left without reset");
    wait_exit_a: assert property (
        |(coreIrqReq | coreDebugReq) |=> (coreWaiting & $past(coreIrqReq | coreDebugReq)) == '0)
        else $error("wait not left");
    clk_mask_a: assert property (
        sysCfgWrite && anyRstN |=> ##1 bus_clock_output ==
            (busClockIn && !$past(bus_clock_output_disable, 2)))
        else $error("bus clock mask off");

    cover property ($rose(cfgDone) && w == 32'h0);
    cover property ($rose(coreStopped[0]));
    cover property (sysCfgWrite && bus_clock_output_disable);
endmodule

bind reset_config_word_decode rcwd_monitor rcwd_monitor_inst (
    .clock, .reset, .power_on_reset_n, .hard_reset_n, .soft_reset_n,
    .sysCfgWrite, .bus_clock_output_disable, .busClockIn, .coreIrqReq,
    .coreDebugReq, .hard_reset_config_word, .cfgDone, .chipSelectFiveEn,
    .busControlOneEn, .transferCodeEn, .bankSelectEn, .host_little_endian_sel,
    .munged_endian_sel, .clock_mode_bits, .systemPllMult, .bus_clock_output,
    .coreStopped, .coreWaiting
);

// ===== testbench/reset_config_word_decode_bench.sv
`timescale 1ns/10ps
module reset_config_word_decode_bench;
    logic        clock = 1'b0, reset = 1'b1, sendGo = 1'b0, sysCfgWrite = 1'b0;
    logic        power_on_reset_n = 1'b0, hard_reset_n = 1'b0;
    logic        soft_reset_n = 1'b1, busClockIn = 1'b1;
    logic        bus_clock_output_disable = 1'b0, cfgWordValid;
    logic [1:0]  clockModePins = 2'h2;
    logic [7:0]  periphClockMask = 8'h0, periphClockIn = 8'hff;
    logic [3:0]  coreStopReq = 4'h0, coreWaitReq = 4'h0;
    logic [3:0]  coreIrqReq = 4'h0, coreDebugReq = 4'h0;
    logic [31:0] sendWord = 32'h0, cfgWordData, hard_reset_config_word;
    logic        cfgDone, chip_select_five_pin_cfg, chipSelectFiveEn;
    logic        busControlOneEn, transferCodeEn, bankSelectEn;
    logic        host_little_endian_sel, munged_endian_sel, reservedBitsBad;
    logic        bus_clock_output;
    logic [1:0]  transfer_code_pin_cfg;
    logic [4:0]  clock_mode_bits, systemPllMult;
    logic [7:0]  periphClockOut;
    logic [3:0]  coreStopped, coreWaiting;
    int          errCount = 0, comparisons = 0, cycles = 0;
    logic [31:0] words [4] = '{32'h5820_0000, 32'h2980_0000,
                               32'h7b20_0000, 32'h0a80_0000};

    rcwd_word_source rcwd_word_source_inst (.clock, .sendGo, .sendWord,
        .cfgWordValid, .cfgWordData);
    reset_config_word_decode reset_config_word_decode_inst (.clock, .reset,
        .power_on_reset_n, .hard_reset_n, .soft_reset_n, .cfgWordValid,
        .cfgWordData, .clockModePins, .sysCfgWrite, .bus_clock_output_disable,
        .periphClockMask, .coreStopReq, .coreWaitReq, .coreIrqReq,
        .coreDebugReq, .busClockIn, .periphClockIn, .hard_reset_config_word,
        .cfgDone, .chip_select_five_pin_cfg, .chipSelectFiveEn,
        .busControlOneEn, .transfer_code_pin_cfg, .transferCodeEn,
        .bankSelectEn, .host_little_endian_sel, .munged_endian_sel,
        .reservedBitsBad, .clock_mode_bits, .systemPllMult, .bus_clock_output,
        .periphClockOut, .coreStopped, .coreWaiting);

    always #4 clock = ~clock;

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            errCount++;
            end_sim();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic send(input logic [31:0] w);
        sendGo = 1'b1;
        sendWord = w;
        step(1);
        sendGo = 1'b0;
        step(2);
    endtask

    task automatic hard_pulse();
        hard_reset_n = 1'b0;
        step(3);
        hard_reset_n = 1'b1;
        step(1);
    endtask

    task automatic check_word(input logic [31:0] w);
        check("word", hard_reset_config_word, w);
        check("done", 32'(cfgDone), 32'h1);
        check("csfive", 32'({chipSelectFiveEn, busControlOneEn,
            chip_select_five_pin_cfg}), 32'({!w[21], w[21], w[21]}));
        check("tcode", 32'({transfer_code_pin_cfg, transferCodeEn, bankSelectEn}),
            32'({w[23:22], w[23:22] == 2'h0, w[23:22] == 2'h2}));
        check("endian", 32'(host_little_endian_sel), 32'(w[24]));
        check("munged", 32'(munged_endian_sel), 32'(w[24] & w[25]));
        check("reserved", 32'(reservedBitsBad), 32'(w[26] | w[31]
            | (w != 32'h0 && !w[27])));
        check("mode", 32'(clock_mode_bits), 32'({w[30:28], 2'h2}));
        check("pll", 32'(systemPllMult), 32'h16);
    endtask

    initial begin
        step(5);
        reset = 1'b0;
        step(2);
        power_on_reset_n = 1'b1;
        step(3);
        clockModePins = 2'h1;
        for (int i = 0; i < 4; i++) begin
            hard_pulse();
            send(words[i]);
            check_word(words[i]);
            send(~words[i]);
            check("held", hard_reset_config_word, words[i]);
        end
        $display("test word decode done");
        hard_pulse();
        step(1010);
        check("early", 32'(cfgDone), 32'h0);
        step(30);
        check_word(32'h0);
        $display("test default word done");
        coreStopReq = 4'h1;
        coreWaitReq = 4'h6;
        step(1);
        coreStopReq = 4'h0;
        coreWaitReq = 4'h0;
        check("modes", 32'({coreStopped, coreWaiting}), 32'h16);
        coreIrqReq = 4'h3;
        coreDebugReq = 4'h4;
        step(1);
        coreIrqReq = 4'h0;
        coreDebugReq = 4'h0;
        check("resume", 32'({coreStopped, coreWaiting}), 32'h10);
        soft_reset_n = 1'b0;
        step(1);
        soft_reset_n = 1'b1;
        check("unstop", 32'({coreStopped, coreWaiting}), 32'h00);
        $display("test core modes done");
        for (int k = 0; k < 2; k++) begin
            sysCfgWrite = 1'b1;
            {bus_clock_output_disable, periphClockMask} = k ? 9'h000 : 9'h10f;
            step(1);
            sysCfgWrite = 1'b0;
            step(1);
            check("gate", 32'({bus_clock_output, periphClockOut}),
                k ? 32'h1ff : 32'h0f0);
        end
        $display("test clock masks done");
        end_sim();
    end
endmodule
